/* ccta_pkg.sv */
package ccta_pkg;

	// counter width and channel count
	localparam int          CNT_W      = 16;
	localparam int          N_CH       = 2;

	// register indices; byte address is four times the index
	localparam logic [7:0]  IDX_TSC    = 8'h40;
	localparam logic [7:0]  IDX_CNTH   = 8'h41;
	localparam logic [7:0]  IDX_CNTL   = 8'h42;
	localparam logic [7:0]  IDX_MODH   = 8'h43;
	localparam logic [7:0]  IDX_MODL   = 8'h44;
	localparam logic [7:0]  IDX_SC0    = 8'h45;
	localparam logic [7:0]  IDX_V0H    = 8'h46;
	localparam logic [7:0]  IDX_V0L    = 8'h47;
	localparam logic [7:0]  IDX_SC1    = 8'h48;
	localparam logic [7:0]  IDX_V1H    = 8'h49;
	localparam logic [7:0]  IDX_V1L    = 8'h4A;
	localparam logic [7:0]  IDX_EVT    = 8'h4B;
	localparam logic [7:0]  IDX_MSK    = 8'h4C;

	// timer and channel status/control fields
	localparam int          TSC_OVF    = 7;
	localparam int          TSC_OVIE   = 6;
	localparam int          TSC_HALT   = 5;
	localparam int          TSC_CRST   = 4;
	localparam int          CHSC_FLAG  = 7;
	localparam int          CHSC_LINK  = 5;
	localparam logic [2:0]  PS_EXT     = 3'h7;

	// reset values
	localparam logic [7:0]  TSC_RST    = 8'h20;
	localparam logic [15:0] MOD_RST    = 16'hFFFF;
	localparam logic [7:0]  CHSC_RST   = 8'h00;

	// edge and compare action encodings
	localparam logic [1:0]  ELS_OFF    = 2'h0;
	localparam logic [1:0]  OC_TOGGLE  = 2'h1;
	localparam logic [1:0]  OC_CLEAR   = 2'h2;
	localparam logic [1:0]  OC_SET     = 2'h3;

	// event status bits
	localparam int          EVT_W      = 3;
	localparam int          EVT_OVF    = 2;

	typedef struct packed {
		logic       flag;
		logic       irq_en;
		logic       link;
		logic       mode_lo;
		logic [1:0] els;
		logic       tog_wrap;
		logic       full_duty;
	} ccta_chsc_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [31:0] dat;
	} ccta_wbreq_t;

endpackage

/* ccta_timer.sv */
// Operation
// - 16-bit up-counter runs free or wraps at the modulo value.
// - reading the counter never disturbs counting.
// - two channels, each capture or compare, set independently.
// - count clock from seven bus-clock taps or the external clock pin.
// - capture on rising, falling or both edges per edge select bits.
// - captured count held as high and low byte registers.
// - active edge copies counter into channel value and sets flag.
// - every qualifying edge captures whether flag is set or clear.
// - captured value appears two cycles after the synchronised edge.
// - a later capture overwrites the earlier value.
// - set flag with its enable raises the interrupt request.
// - compare match can set, clear or toggle the pin.
// - each channel may toggle its pin on counter overflow.
// - halt bit stops counting; reset control clears counter, reads zero.
// - compare acts when counter equals channel value, sets flag.
// - linked mode: last written channel controls pin 0 after overflow.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
module ccta_timer
	import ccta_pkg::*;
#(
	parameter int ADR_W = 10
)(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic [ADR_W-1:0]  wb_adr,
	input  wire ccta_wbreq_t       wb_req,
	output      logic [31:0]       wb_dat_o,
	output      logic              wb_ack_o,
	input  wire logic              external_count_clock_pin,
	input  wire logic              chan0_pin_in,
	output      logic              chan0_pin_out,
	output      logic              chan0_pin_oe,
	input  wire logic              chan1_pin_in,
	output      logic              chan1_pin_out,
	output      logic              chan1_pin_oe,
	output      logic              irq
);

	if (ADR_W < 10)
		$error("ADR_W must be at least 10");
	function automatic logic tap_hit(input logic [5:0] p, input logic [2:0] ps);
		logic [5:0] m;
		m = 6'((7'h01 << ps) - 7'h01);
		return (p & m) == m;
	endfunction
	function automatic logic edge_hit(input logic [1:0] els, input logic now, input logic was);
		return (els[0] & now & ~was) | (els[1] & ~now & was);
	endfunction
	logic [7:0]        tsc;
	logic [15:0]       cnt;
	logic [15:0]       modv;
	logic [5:0]        pre;
	ccta_chsc_t        sc   [N_CH];
	logic [15:0]       chv  [N_CH];
	logic              buf_sel;
	logic              last_wr;
	logic [EVT_W-1:0]  evt;
	logic [EVT_W-1:0]  msk;
	logic              ext_s1, ext_s2, ext_s3;
	logic [N_CH-1:0]   pin_s1, pin_s2, pin_s3;
	logic [N_CH-1:0]   pin_q;
	logic [7:0]        idx;
	logic              wr;
	logic              rd_req;
	logic [7:0]        wd;
	logic              tick;
	logic              wrap;
	logic              crst;
	logic [15:0]       next_cnt;
	logic [N_CH-1:0]   cap_hit;
	logic [N_CH-1:0]   cmp_hit;
	logic [N_CH-1:0]   oc_mode;
	logic [N_CH-1:0]   next_pin;
	logic [7:0]        rd_byte;
	logic              link;
	// bus decode
	always_comb
	begin
		idx    = ((wb_adr >> 10) == '0) ? wb_adr[9:2] : 8'h00;
		rd_req = wb_req.cyc & wb_req.stb & ~wb_ack_o;
		wr     = wb_req.cyc & wb_req.stb & wb_req.we & wb_ack_o & wb_req.sel[0];
		wd     = wb_req.dat[7:0];
		link   = sc[0].link;
	end
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
		end
		else
		begin
			ext_s1 <= external_count_clock_pin;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			pin_s1 <= {chan1_pin_in, chan0_pin_in};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end
	// count enable and wrap
	always_comb
	begin
		if (tsc[TSC_HALT])
			tick = 1'b0;
		else if (tsc[2:0] == PS_EXT)
			tick = ext_s2 & ~ext_s3;
		else
			tick = tap_hit(pre, tsc[2:0]);
		wrap     = tick && (cnt == modv);
		next_cnt = wrap ? 16'h0000 : 16'(cnt + 16'h0001);
		crst     = wr && (idx == IDX_TSC) && wd[TSC_CRST];
	end
	always_comb
	begin
		for (int i = 0; i < N_CH; i++)
		begin
			logic [15:0] cv;
			logic        used;
			cv         = (i == 0 && link && buf_sel) ? chv[1] : chv[i];
			used       = !(i == 1 && link);
			oc_mode[i] = used && (sc[i].mode_lo || (i == 0 && link)) && sc[i].els != ELS_OFF;
			cap_hit[i] = used && !sc[i].mode_lo && !(i == 0 && link)
				&& edge_hit(sc[i].els, pin_s2[i], pin_s3[i]);
			cmp_hit[i] = oc_mode[i] && tick && (next_cnt == cv);
			next_pin[i] = pin_q[i];
			if (cmp_hit[i])
			begin
				case (sc[i].els)
					OC_TOGGLE: next_pin[i] = ~pin_q[i];
					OC_CLEAR:  next_pin[i] = 1'b0;
					OC_SET:    next_pin[i] = 1'b1;
					default:   next_pin[i] = pin_q[i];
				endcase
			end
			if (wrap && sc[i].tog_wrap)
				next_pin[i] = ~next_pin[i];
			if (sc[i].full_duty && sc[i].tog_wrap)
				next_pin[i] = 1'b1;
		end
	end
	// prescaler and counter
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pre <= '0;
			cnt <= '0;
		end
		else if (crst)
		begin
			pre <= '0;
			cnt <= '0;
		end
		else
		begin
			pre <= pre + 6'h01;
			if (tick)
				cnt <= next_cnt;
		end
	end
	// timer status/control and modulo
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			tsc  <= TSC_RST;
			modv <= MOD_RST;
		end
		else
		begin
			if (wr && idx == IDX_TSC)
			begin
				tsc[6:5] <= wd[6:5];
				tsc[2:0] <= wd[2:0];
			end
			if (wrap)
				tsc[TSC_OVF] <= 1'b1;
			else if (wr && idx == IDX_TSC && !wd[TSC_OVF])
				tsc[TSC_OVF] <= 1'b0;
			if (wr && idx == IDX_MODH)
				modv[15:8] <= wd;
			if (wr && idx == IDX_MODL)
				modv[7:0] <= wd;
		end
	end
	// channel status/control and values
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < N_CH; i++)
			begin
				sc[i]  <= CHSC_RST;
				chv[i] <= '0;
			end
		end
		else
		begin
			for (int i = 0; i < N_CH; i++)
			begin
				if (wr && idx == (i == 0 ? IDX_SC0 : IDX_SC1))
				begin
					sc[i][6:0] <= wd[6:0];
					if (i == 1)
						sc[i].link <= 1'b0;
				end
				if (cap_hit[i] || cmp_hit[i])
					sc[i].flag <= 1'b1;
				else if (wr && idx == (i == 0 ? IDX_SC0 : IDX_SC1) && !wd[CHSC_FLAG])
					sc[i].flag <= 1'b0;
				if (wr && idx == (i == 0 ? IDX_V0H : IDX_V1H))
					chv[i][15:8] <= wd;
				if (wr && idx == (i == 0 ? IDX_V0L : IDX_V1L))
					chv[i][7:0] <= wd;
				if (cap_hit[i])
					chv[i] <= cnt;
			end
		end
	end
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			buf_sel <= 1'b0;
			last_wr <= 1'b0;
		end
		else
		begin
			if (wr && (idx == IDX_V0H || idx == IDX_V0L))
				last_wr <= 1'b0;
			else if (wr && (idx == IDX_V1H || idx == IDX_V1L))
				last_wr <= 1'b1;
			if (!link)
				buf_sel <= 1'b0;
			else if (wrap)
				buf_sel <= last_wr;
		end
	end
	// event status, mask, interrupt
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			evt <= '0;
			msk <= '0;
			irq <= 1'b0;
		end
		else
		begin
			evt <= (evt & ~((wr && idx == IDX_EVT) ? wd[EVT_W-1:0] : '0))
				| {wrap, cap_hit[1] | cmp_hit[1], cap_hit[0] | cmp_hit[0]};
			if (wr && idx == IDX_MSK)
				msk <= wd[EVT_W-1:0];
			irq <= |(evt & msk) | (tsc[TSC_OVF] & tsc[TSC_OVIE])
				| (sc[0].flag & sc[0].irq_en) | (sc[1].flag & sc[1].irq_en);
		end
	end
	// channel pins
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pin_q         <= '0;
			chan0_pin_out <= 1'b0;
			chan0_pin_oe  <= 1'b0;
			chan1_pin_out <= 1'b0;
			chan1_pin_oe  <= 1'b0;
		end
		else
		begin
			pin_q         <= next_pin;
			chan0_pin_out <= next_pin[0];
			chan0_pin_oe  <= oc_mode[0];
			chan1_pin_out <= next_pin[1];
			chan1_pin_oe  <= oc_mode[1];
		end
	end
	// register read
	always_comb
	begin
		case (idx)
			IDX_TSC:  rd_byte = {tsc[7:5], 2'b00, tsc[2:0]};
			IDX_CNTH: rd_byte = cnt[15:8];
			IDX_CNTL: rd_byte = cnt[7:0];
			IDX_MODH: rd_byte = modv[15:8];
			IDX_MODL: rd_byte = modv[7:0];
			IDX_SC0:  rd_byte = sc[0];
			IDX_V0H:  rd_byte = chv[0][15:8];
			IDX_V0L:  rd_byte = chv[0][7:0];
			IDX_SC1:  rd_byte = sc[1];
			IDX_V1H:  rd_byte = chv[1][15:8];
			IDX_V1L:  rd_byte = chv[1][7:0];
			IDX_EVT:  rd_byte = {5'h00, evt};
			IDX_MSK:  rd_byte = {5'h00, msk};
			default:  rd_byte = 8'h00;
		endcase
	end
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			wb_ack_o <= rd_req;
			if (rd_req)
				wb_dat_o <= {24'h000000, rd_byte};
		end
	end
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_count_step: assert property (tick && !wrap && !crst |=> cnt == $past(cnt) + 16'h0001)
		else $error("counter did not step by one");
	a_read_quiet: assert property (rd_req && !wb_req.we && !tick && !crst |=> cnt == $past(cnt))
		else $error("read disturbed counter");
	a_tap_div4: assert property (tick && tsc[2:0] == 3'h2 |-> pre[1:0] == 2'b11)
		else $error("prescaler tap wrong");
	a_capture_delay: assert property ($rose(chan0_pin_in) && !sc[0].mode_lo && !link
		&& sc[0].els == 2'b01 ##1 $stable(sc[0]) [*2] |-> cap_hit[0])
		else $error("capture not two cycles after edge");
	a_capture_load: assert property (cap_hit[0] |=> chv[0] == $past(cnt) && sc[0].flag)
		else $error("capture did not latch count and flag");
	a_irq_raise: assert property (sc[1].flag && sc[1].irq_en |=> irq)
		else $error("interrupt not raised");
	a_cmp_set: assert property (cmp_hit[0] && sc[0].els == OC_SET && !sc[0].tog_wrap |=> chan0_pin_out)
		else $error("compare set failed");
	a_wrap_toggle: assert property (wrap && sc[1].tog_wrap && !sc[1].full_duty && !cmp_hit[1]
		|=> chan1_pin_out != $past(chan1_pin_out))
		else $error("overflow toggle missing");
	a_halt_hold: assert property (tsc[TSC_HALT] && !crst |=> $stable(cnt))
		else $error("counter moved while halted");
	a_crst_clear: assert property (crst |=> cnt == 16'h0000 && pre == 6'h00)
		else $error("counter reset failed");
	a_link_swap: assert property (link && wrap |=> buf_sel == $past(last_wr))
		else $error("linked swap wrong");
	a_wrap_zero: assert property (wrap |=> cnt == 16'h0000 && tsc[TSC_OVF])
		else $error("wrap did not clear counter");
	a_flag_keep: assert property (tsc[TSC_OVF] && wr && idx == IDX_TSC && wd[TSC_OVF] |=> tsc[TSC_OVF])
		else $error("writing one cleared flag");
	c_capture: cover property (cap_hit[0] ##[1:50] cap_hit[0]);
	c_compare: cover property (cmp_hit[1]);
	c_wrap: cover property (wrap && modv != MOD_RST);
	c_link: cover property (link && wrap && last_wr);

endmodule

/* ccta_pin_model.sv */
`timescale 1ns/1ps
module ccta_pin_model (
	input  wire logic clk_sys,
	output      logic ext_clk,
	output      logic drv0,
	output      logic drv1
);
	initial
	begin
		ext_clk = 1'b0;
		drv0    = 1'b0;
		drv1    = 1'b0;
	end
	// external count clock, still between bursts
	task automatic ext_burst(input int n, input int slow);
		repeat (n)
		begin
			@(posedge clk_sys) ext_clk <= 1'b1;
			repeat (slow) @(posedge clk_sys);
			@(posedge clk_sys) ext_clk <= 1'b0;
			repeat (slow) @(posedge clk_sys);
		end
	endtask
	// move one channel pin, then let it settle
	task automatic set_pin(input bit ch, input logic v);
		@(posedge clk_sys);
		if (ch)
			drv1 <= v;
		else
			drv0 <= v;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule

/* ccta_timer_tb.sv */
`timescale 1ns/1ps
module ccta_timer_tb;
	import ccta_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst     = 1'b1;
	logic [9:0]  wb_adr  = '0;
	ccta_wbreq_t wb_req  = '0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        ext_clk;
	logic        drv0;
	logic        drv1;
	logic        p0_out;
	logic        p0_oe;
	logic        p1_out;
	logic        p1_oe;
	logic        irq;
	int          n_errors = 0;
	int          samples_checked = 0;

	always #10 clk_sys = ~clk_sys;

	ccta_timer uut (.clk_sys(clk_sys), .rst(rst), .wb_adr(wb_adr), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .external_count_clock_pin(ext_clk), .chan0_pin_in(p0_oe ? p0_out : drv0),
		.chan0_pin_out(p0_out), .chan0_pin_oe(p0_oe), .chan1_pin_in(p1_oe ? p1_out : drv1),
		.chan1_pin_out(p1_out), .chan1_pin_oe(p1_oe), .irq(irq));
	ccta_pin_model pins (.clk_sys(clk_sys), .ext_clk(ext_clk), .drv0(drv0), .drv1(drv1));

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic fail_to();
		n_errors++;
		$display("wrong value at %0t: wait ran out", $time);
		print_verdict();
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string s);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: %s got %h want %h", $time, s, got, exp);
		end
	endtask
	// one classic cycle, held until ack, then one idle cycle
	task automatic wb(input logic [7:0] idx, input logic we, input logic [7:0] d, output logic [7:0] q);
		int i;
		wb_adr <= {idx, 2'b00};
		wb_req <= {3'b111 & {2'b11, we}, 4'h1, 24'h0, d};
		i = 0;
		do
		begin
			@(posedge clk_sys);
			i++;
		end
		while (wb_ack_o !== 1'b1 && i < 50);
		if (i >= 50)
			fail_to();
		q = wb_dat_o[7:0];
		wb_req <= '0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		wb(idx, 1'b1, d, q);
	endtask
	task automatic rc(input logic [7:0] idx, input logic [7:0] e, input string s);
		logic [7:0] q;
		wb(idx, 1'b0, 8'h00, q);
		check({8'h00, q}, {8'h00, e}, s);
	endtask
	task automatic wait_pin(input bit ch, input logic v, output int n);
		n = 0;
		while ((ch ? p1_out : p0_out) !== v && n < 2500)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 2500)
			fail_to();
	endtask
	task automatic irq_is(input logic e);
		repeat (2) @(posedge clk_sys);
		check({15'h0, irq}, {15'h0, e}, "irq");
	endtask

	task automatic t_reset();
		rc(IDX_TSC, TSC_RST, "tsc");
		rc(IDX_MODH, MOD_RST[15:8], "modh");
		rc(IDX_MODL, MOD_RST[7:0], "modl");
		rc(IDX_SC0, CHSC_RST, "sc0");
		wr(IDX_CNTH, 8'h12);
		rc(IDX_CNTH, 8'h00, "cnt ro");
		wr(8'h10, 8'h55);
		rc(8'h10, 8'h00, "unmapped");
	endtask
	task automatic t_count();
		logic [7:0] a;
		logic [7:0] b;
		wr(IDX_TSC, 8'h00);
		wb(IDX_CNTL, 1'b0, 8'h00, a);
		wb(IDX_CNTL, 1'b0, 8'h00, b);
		check({8'h0, b - a}, 16'h0003, "count step");
		wr(IDX_TSC, 8'h20);
		wb(IDX_CNTL, 1'b0, 8'h00, a);
		wb(IDX_CNTL, 1'b0, 8'h00, b);
		check({8'h0, b}, {8'h0, a}, "halted");
		wr(IDX_TSC, 8'h30);
		rc(IDX_CNTL, 8'h00, "cnt clr");
		rc(IDX_TSC, 8'h20, "crst reads 0");
	endtask
	task automatic t_wrap();
		wr(IDX_MODH, 8'h00);
		wr(IDX_MODL, 8'h10);
		wr(IDX_TSC, 8'h40);
		repeat (20) @(posedge clk_sys);
		wr(IDX_TSC, 8'hE0);
		rc(IDX_TSC, 8'hE0, "ovf kept");
		irq_is(1'b1);
		rc(IDX_CNTH, 8'h00, "cnt high");
		wr(IDX_TSC, 8'h60);
		rc(IDX_TSC, 8'h60, "ovf clr");
		irq_is(1'b0);
	endtask
	task automatic t_capture();
		logic [7:0] c;
		wr(IDX_SC0, 8'h44);
		wr(IDX_TSC, 8'h00);
		wr(IDX_TSC, 8'h20);
		wb(IDX_CNTL, 1'b0, 8'h00, c);
		pins.set_pin(1'b0, 1'b1);
		rc(IDX_V0H, 8'h00, "cap hi");
		rc(IDX_V0L, c, "cap lo");
		rc(IDX_SC0, 8'hC4, "cap flag");
		irq_is(1'b1);
		pins.set_pin(1'b0, 1'b0);
		wr(IDX_TSC, 8'h00);
		wr(IDX_TSC, 8'h20);
		wb(IDX_CNTL, 1'b0, 8'h00, c);
		pins.set_pin(1'b0, 1'b1);
		rc(IDX_V0L, c, "recapture");
		wr(IDX_SC0, 8'h44);
		rc(IDX_SC0, 8'h44, "flag clr");
		irq_is(1'b0);
		rc(IDX_EVT, 8'h05, "events");
		wr(IDX_MSK, 8'h01);
		irq_is(1'b1);
		wr(IDX_EVT, 8'h01);
		irq_is(1'b0);
		rc(IDX_EVT, 8'h04, "evt clr");
		wr(IDX_MSK, 8'h00);
	endtask
	task automatic t_edges();
		logic [1:0] m;
		for (int k = 1; k < 4; k++)
		begin
			m = 2'(k);
			wr(IDX_SC1, {4'h0, m, 2'b00});
			pins.set_pin(1'b1, 1'b1);
			rc(IDX_SC1, {m != 2'h2, 3'h0, m, 2'b00}, "rise");
			wr(IDX_SC1, {4'h0, m, 2'b00});
			pins.set_pin(1'b1, 1'b0);
			rc(IDX_SC1, {m != 2'h1, 3'h0, m, 2'b00}, "fall");
		end
	endtask
	task automatic t_compare();
		int n;
		logic p;
		wr(IDX_V0H, 8'h00);
		wr(IDX_V0L, 8'h05);
		wr(IDX_SC0, 8'h1C);
		wr(IDX_TSC, 8'h00);
		wait_pin(1'b0, 1'b1, n);
		check({15'h0, p0_oe}, 16'h0001, "oe");
		wr(IDX_SC0, 8'h18);
		wait_pin(1'b0, 1'b0, n);
		wr(IDX_SC0, 8'h14);
		p = p0_out;
		wait_pin(1'b0, ~p, n);
		wait_pin(1'b0, p, n);
		check(16'(n), 16'd17, "toggle gap");
		rc(IDX_SC0, 8'h94, "cmp flag");
		irq_is(1'b0);
	endtask
	task automatic t_prescale();
		int n;
		logic p;
		wr(IDX_V1H, 8'h00);
		wr(IDX_V1L, 8'hFF);
		wr(IDX_SC1, 8'h1A);
		for (int ps = 0; ps < 7; ps++)
		begin
			wr(IDX_TSC, 8'(ps));
			p = p1_out;
			wait_pin(1'b1, ~p, n);
			wait_pin(1'b1, p, n);
			check(16'(n), 16'(17 << ps), "wrap gap");
		end
		wr(IDX_TSC, 8'h37);
		wr(IDX_TSC, 8'h07);
		p = p1_out;
		pins.ext_burst(16, 3);
		check({15'h0, p1_out}, {15'h0, p}, "ext 16");
		pins.ext_burst(1, 3);
		check({15'h0, p1_out}, {15'h0, ~p}, "ext 17");
	endtask

	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_count();
		t_wrap();
		t_capture();
		t_edges();
		t_compare();
		t_prescale();
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rc(IDX_TSC, TSC_RST, "second reset");
		check({14'h0, p0_oe, p1_oe}, 16'h0000, "oe reset");
		print_verdict();
	end
endmodule
